// ==== shared/disc_buffer_pkg.sv ====
// Constants, types and register map of the disc word buffer.
package disc_buffer_pkg;
  // Clock and end-of-subsector hold-off time
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned END_TIME_NS = 2000;
  localparam int unsigned END_CYCLES = (END_TIME_NS * CLK_MHZ) / 1000;
  // Register byte addresses
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_DATA = 4'h8;
  localparam logic [3:0] OFF_ERROR = 4'hc;
  // Control and error register field positions
  localparam int CTRL_READ_BIT = 0;
  localparam int CTRL_DIAG_BIT = 1;
  localparam int CTRL_INIT_BIT = 2;
  localparam int ERROR_CHECK_BIT = 15;
  // Occupancy load values: low bits and top bit
  localparam logic [3:0] OCC_INIT_LOW = 4'hf;
  localparam logic OCC_TOP_NORMAL = 1'b0;
  localparam logic OCC_TOP_DIAG = 1'b1;
  localparam logic [4:0] OCC_FULL = 5'h1f;
  // Bit positions within a word for pacing, and the last word of a subsector
  localparam logic [3:0] WRITE_BLOCK_FROM = 4'hd;
  localparam logic [3:0] WRITE_RESUME = 4'h1;
  localparam logic [3:0] READ_BLOCK_FROM = 4'hd;
  localparam logic [3:0] READ_RESUME = 4'h2;
  localparam logic [3:0] LAST_BIT = 4'hf;
  localparam logic [3:0] LAST_WORD = 4'hf;
  // Reset values
  localparam logic [15:0] CHECK_RESET = 16'h0000;
  localparam logic PARITY_PRESET = 1'b1;
  // Serial phase within a subsector
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_DATA = 3'b001,
    PH_CHECK = 3'b010,
    PH_PARITY = 3'b011,
    PH_END = 3'b100
  } phase_t;
  // Status register layout
  typedef struct packed {
    logic read_check_error;
    logic check_word_cycle_flag;
    logic parity_cycle_flag;
    logic end_busy;
    logic data_register_full_flag;
    logic buffer_full_flag;
    logic buffer_empty_n;
    logic read_operation_flag;
    logic diagnostic_read_select;
    logic [4:0] occupancy;
    logic [1:0] zero_pad;
  } status_t;
endpackage

// ==== src/disc_word_buffer.sv ====
// Sixteen-word disc buffer with transfer pacing and check-word logic.
`timescale 1ns/100ps
module disc_word_buffer
  import disc_buffer_pkg::*;
#(
  parameter logic [15:0] CHECK_POLY = 16'h8005 // Plain default, not a known part
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rdata,
  input wire logic word_clock,
  input wire logic subsector_start,
  input wire logic write_active_flag,
  input wire logic read_gate,
  input wire logic write_sector_go,
  input wire logic serial_in,
  output logic serial_out,
  output logic buffer_empty_n,
  output logic buffer_full_flag,
  output logic buffer_full_n,
  output logic data_register_strobe,
  output logic buffer_to_serial_load_pulse,
  output logic buffer_to_host_transfer_pulse,
  output logic buffer_write_pulse,
  output logic shift_register_load_pulse,
  output logic data_taken_strobe,
  output logic read_check_error,
  output logic check_word_cycle_flag,
  output logic parity_cycle_flag
);

  // One step of the check-word generator
  function automatic logic [15:0] check_step(input logic [15:0] c, input logic b);
    check_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CHECK_POLY : 16'h0000);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [15:0] mem [16]; // Buffer words
  logic [3:0] wr_ptr; // Next slot to fill
  logic [3:0] rd_ptr; // Oldest word
  logic [4:0] occupancy; // Top bit is not-empty
  logic read_operation_flag; // Mode from control
  logic diagnostic_read_select; // Diagnostic re-read mode
  logic data_register_full_flag; // Host data register holds a word
  logic [15:0] data_reg; // Host-facing data register
  logic delayed_word_clock; // Word clock one cycle late
  logic slot; // Alternating word-clock divider
  phase_t phase; // Subsector phase
  logic [3:0] bit_cnt; // Bits done in current word
  logic [3:0] word_cnt; // Words done in subsector
  logic [15:0] shifter; // Serial shift register
  logic [15:0] check_word; // Running check word
  logic running_parity_flag; // Toggles on each one bit
  logic [7:0] end_cnt; // End-of-subsector timer
  logic end_of_subsector_timer; // Timer running
  logic [4:0] next_occupancy;
  logic go_armed; // First shift load still owed on go

  ////////////////////////////////////////////////////////////////////////////
  // Decodes
  logic ctrl_wr, init_now, chan_out, chan_in, bit_tick, active_tick;
  logic slot_tick, quiet, load_now, host_xfer_now, store_now, shift_load_now;
  logic last_bit, in_data, write_blk, read_blk, cur_bit;
  logic [15:0] assembled;

  assign ctrl_wr = wr_en && (addr == OFF_CTRL);
  assign init_now = ctrl_wr && wdata[CTRL_INIT_BIT];
  assign chan_out = wr_en && (addr == OFF_DATA) && !read_operation_flag;
  assign chan_in = rd_en && (addr == OFF_DATA) && read_operation_flag;
  assign bit_tick = word_clock && !delayed_word_clock;
  // Serial work only while the sector match has opened the gate
  assign active_tick = bit_tick && (read_operation_flag ? read_gate : write_active_flag);
  assign slot_tick = bit_tick && slot;
  assign in_data = (phase == PH_DATA);
  assign last_bit = (bit_cnt == LAST_BIT);
  // Window near the word boundary where the shifter is busy
  assign write_blk = (bit_cnt >= WRITE_BLOCK_FROM) || (bit_cnt < WRITE_RESUME);
  assign read_blk = (bit_cnt >= READ_BLOCK_FROM) || (bit_cnt < READ_RESUME);
  // Check, parity and end phases all keep the transfers off
  assign quiet = (phase != PH_CHECK) && (phase != PH_PARITY)
    && !end_of_subsector_timer;

  // Write: host word into buffer
  assign load_now = !read_operation_flag && data_register_full_flag
    && (occupancy != OCC_FULL) && quiet && !write_blk && slot_tick
    && !buffer_to_serial_load_pulse;
  // Read: oldest word to host register, only while delayed clock low
  assign host_xfer_now = read_operation_flag && occupancy[4] && !data_register_full_flag
    && quiet && !read_blk && slot && !delayed_word_clock
    && !buffer_to_host_transfer_pulse;
  // Read: a full word assembled from the disc
  assign assembled = {shifter[14:0], serial_in};
  assign store_now = read_operation_flag && active_tick && in_data && last_bit;
  // Write: first word on go, then at each word boundary except after the last word
  // Go loads once per subsector and never on an active bit tick, so a held go
  // level cannot drain the buffer or swallow the first bit
  assign shift_load_now = !read_operation_flag && occupancy[4] && in_data
    && ((write_sector_go && go_armed && !active_tick && bit_cnt == 4'h0 && word_cnt == 4'h0)
      || (active_tick && last_bit && word_cnt != LAST_WORD));
  assign cur_bit = (phase == PH_CHECK) ? check_word[15] : shifter[15];

  ////////////////////////////////////////////////////////////////////////////
  // Mode control
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      read_operation_flag <= 1'b0;
      diagnostic_read_select <= 1'b0;
    end else if (ce && ctrl_wr) begin
      read_operation_flag <= wdata[CTRL_READ_BIT];
      diagnostic_read_select <= wdata[CTRL_DIAG_BIT];
    end
  end

  // Word clock delay and every-other-clock divider
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      delayed_word_clock <= 1'b0;
      slot <= 1'b0;
    end else if (ce) begin
      delayed_word_clock <= word_clock;
      if (bit_tick) begin
        slot <= !slot;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Occupancy: increments at end of any fill, decrements at end of any drain
  always_comb begin
    next_occupancy = occupancy;
    if (buffer_to_serial_load_pulse || buffer_write_pulse) begin
      next_occupancy = next_occupancy + 5'h01;
    end
    // Drain event depends on direction
    if (read_operation_flag ? buffer_to_host_transfer_pulse
        : shift_register_load_pulse) begin
      next_occupancy = next_occupancy - 5'h01;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      occupancy <= {OCC_TOP_NORMAL, OCC_INIT_LOW};
    end else if (ce) begin
      if (init_now) begin
        // Diagnostic mode pretends full so the buffer can be re-read
        occupancy <= {wdata[CTRL_DIAG_BIT] ? OCC_TOP_DIAG : OCC_TOP_NORMAL,
          OCC_INIT_LOW};
      end else begin
        occupancy <= next_occupancy;
      end
    end
  end

  // Pointers and buffer array
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
    end else if (ce) begin
      if (init_now) begin
        wr_ptr <= 4'h0;
        rd_ptr <= 4'h0;
      end else begin
        if (load_now || store_now) begin
          wr_ptr <= wr_ptr + 4'h1;
        end
        if (host_xfer_now || shift_load_now) begin
          rd_ptr <= rd_ptr + 4'h1;
        end
      end
    end
  end

  // Array has no reset; contents are don't-care until written
  always_ff @(posedge clk) begin
    if (ce && load_now) begin
      mem[wr_ptr] <= data_reg;
    end else if (ce && store_now) begin
      mem[wr_ptr] <= assembled;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data register and its full flag; init clears first, otherwise a set beats a clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_reg <= 16'h0000;
      data_register_full_flag <= 1'b0;
    end else if (ce) begin
      if (chan_out) begin
        data_reg <= wdata;
      end else if (host_xfer_now) begin
        data_reg <= mem[rd_ptr];
      end
      if (init_now) begin
        data_register_full_flag <= 1'b0;
      end else if ((data_register_strobe && !read_operation_flag)
          || buffer_to_host_transfer_pulse) begin
        data_register_full_flag <= 1'b1;
      end else if (data_taken_strobe || buffer_to_serial_load_pulse) begin
        data_register_full_flag <= 1'b0;
      end
    end
  end

  // Transfer pulses, one cycle each
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_register_strobe <= 1'b0;
      buffer_to_serial_load_pulse <= 1'b0;
      buffer_to_host_transfer_pulse <= 1'b0;
      buffer_write_pulse <= 1'b0;
      shift_register_load_pulse <= 1'b0;
      data_taken_strobe <= 1'b0;
    end else if (ce) begin
      data_register_strobe <= chan_out || host_xfer_now;
      buffer_to_serial_load_pulse <= load_now;
      buffer_to_host_transfer_pulse <= host_xfer_now;
      buffer_write_pulse <= store_now;
      shift_register_load_pulse <= shift_load_now;
      data_taken_strobe <= chan_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial engine: data words, check word, parity bit, end hold-off
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase <= PH_IDLE;
      bit_cnt <= 4'h0;
      word_cnt <= 4'h0;
      shifter <= 16'h0000;
      check_word <= CHECK_RESET;
      running_parity_flag <= PARITY_PRESET;
      serial_out <= 1'b0;
      read_check_error <= 1'b0;
      end_cnt <= 8'h00;
      end_of_subsector_timer <= 1'b0;
      go_armed <= 1'b0;
    end else if (ce) begin
      if (init_now) begin
        read_check_error <= 1'b0;
      end
      if (subsector_start) begin
        phase <= PH_DATA;
        go_armed <= 1'b1;
        bit_cnt <= 4'h0;
        word_cnt <= 4'h0;
        check_word <= CHECK_RESET;
        running_parity_flag <= PARITY_PRESET;
      end else if (shift_load_now) begin
        shifter <= mem[rd_ptr];
        go_armed <= 1'b0;
        if (active_tick) begin
          serial_out <= shifter[15];
          check_word <= check_step(check_word, shifter[15]);
          running_parity_flag <= running_parity_flag ^ shifter[15];
          bit_cnt <= 4'h0;
          word_cnt <= word_cnt + 4'h1;
        end
      end else if (active_tick) begin
        case (phase)
          PH_DATA: begin
            // Writes send the shifter top; reads take the disc bit
            if (read_operation_flag) begin
              shifter <= assembled;
              check_word <= check_step(check_word, serial_in);
              running_parity_flag <= running_parity_flag ^ serial_in;
            end else begin
              serial_out <= shifter[15];
              shifter <= {shifter[14:0], 1'b0};
              check_word <= check_step(check_word, shifter[15]);
              running_parity_flag <= running_parity_flag ^ shifter[15];
            end
            bit_cnt <= bit_cnt + 4'h1;
            if (last_bit) begin
              word_cnt <= word_cnt + 4'h1;
              if (word_cnt == LAST_WORD) begin
                phase <= PH_CHECK;
              end
            end
          end
          PH_CHECK: begin
            // Parity also counts the check word's ones
            if (read_operation_flag) begin
              if (serial_in != check_word[15]) begin
                read_check_error <= 1'b1;
              end
              running_parity_flag <= running_parity_flag ^ serial_in;
            end else begin
              serial_out <= cur_bit;
              running_parity_flag <= running_parity_flag ^ cur_bit;
            end
            check_word <= {check_word[14:0], 1'b0};
            bit_cnt <= bit_cnt + 4'h1;
            if (last_bit) begin
              phase <= PH_PARITY;
            end
          end
          PH_PARITY: begin
            // Preset flag makes the stored bit give odd total ones
            if (read_operation_flag) begin
              if (running_parity_flag ^ serial_in) begin
                read_check_error <= 1'b1;
              end
            end else begin
              serial_out <= running_parity_flag;
            end
            phase <= PH_END;
            end_cnt <= 8'h00;
            end_of_subsector_timer <= 1'b1;
          end
          default: begin
          end
        endcase
      end
      // Timer runs on the system clock, not the word clock
      if (end_of_subsector_timer) begin
        end_cnt <= end_cnt + 8'h01;
        if (end_cnt == 8'(END_CYCLES - 1)) begin
          end_of_subsector_timer <= 1'b0;
          phase <= PH_IDLE;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered flags and register read port
  status_t status;

  always_comb begin
    status = '0;
    status.read_check_error = read_check_error;
    status.check_word_cycle_flag = (phase == PH_CHECK);
    status.parity_cycle_flag = (phase == PH_PARITY);
    status.end_busy = end_of_subsector_timer;
    status.data_register_full_flag = data_register_full_flag;
    status.buffer_full_flag = (occupancy == OCC_FULL);
    status.buffer_empty_n = occupancy[4];
    status.read_operation_flag = read_operation_flag;
    status.diagnostic_read_select = diagnostic_read_select;
    status.occupancy = occupancy;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      buffer_empty_n <= 1'b0;
      buffer_full_flag <= 1'b0;
      buffer_full_n <= 1'b1;
      check_word_cycle_flag <= 1'b0;
      parity_cycle_flag <= 1'b0;
    end else if (ce) begin
      buffer_empty_n <= status.buffer_empty_n;
      buffer_full_flag <= status.buffer_full_flag;
      buffer_full_n <= !status.buffer_full_flag;
      check_word_cycle_flag <= status.check_word_cycle_flag;
      parity_cycle_flag <= status.parity_cycle_flag;
    end
  end

  // Read data valid the cycle after the strobe; zero otherwise
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 16'h0000;
    end else if (ce) begin
      rdata <= 16'h0000;
      if (rd_en) begin
        case (addr)
          OFF_CTRL: rdata <= {13'h0000, 1'b0, diagnostic_read_select, read_operation_flag};
          OFF_STATUS: rdata <= status;
          OFF_DATA: rdata <= data_reg;
          OFF_ERROR: rdata <= {read_check_error, 15'h0000};
          default: rdata <= 16'h0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  load_quiet_a: assert property ((ce && phase inside {PH_CHECK, PH_PARITY}) |=>
    !buffer_to_serial_load_pulse) else $error("load pulse in check or parity cycle");
  end_hold_a: assert property ((ce && end_of_subsector_timer) |=>
    !buffer_to_host_transfer_pulse && !buffer_to_serial_load_pulse)
    else $error("transfer during end hold-off");
  xfer_full_a: assert property ((ce && buffer_to_host_transfer_pulse) |=>
    data_register_full_flag && data_register_strobe == 1'b0 || !ce)
    else $error("full flag not set after transfer");
  taken_clear_a: assert property ((ce && data_taken_strobe
    && !buffer_to_host_transfer_pulse && !init_now) |=> !data_register_full_flag)
    else $error("full flag kept");
  occ_count_a: assert property ((ce && !init_now && buffer_write_pulse
    && !buffer_to_host_transfer_pulse) |=> occupancy == $past(occupancy) + 5'h01)
    else $error("occupancy did not count up");
  diag_init_a: assert property ((ce && init_now) |=>
    occupancy == {$past(wdata[CTRL_DIAG_BIT]), OCC_INIT_LOW}) else $error("bad init load");
  full_flag_a: assert property (ce |=>
    buffer_full_flag == ($past(occupancy) == OCC_FULL) && buffer_full_n != buffer_full_flag)
    else $error("full flag wrong");
  sub_start_a: assert property ((ce && subsector_start) |=>
    check_word == CHECK_RESET && running_parity_flag) else $error("subsector preset");
  shift_once_a: assert property ((ce && shift_register_load_pulse) |=>
    !shift_register_load_pulse) else $error("shift load repeated");
endmodule

// ==== tb/disc_serial_model.sv ====
// Disc side model: bit clock and serial read data for one subsector.
`timescale 1ns/100ps
module disc_serial_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic run,
  input wire logic parity_bit,
  output logic word_clock,
  output logic serial_in,
  output logic frame_done
);
  // Subsector length: 256 data bits, 16 check bits, one parity bit
  localparam int BITS = 273;
  logic [2:0] phase; // Position inside an eight-clock bit cell
  int bit_idx; // Next bit to send
  ////////////////////////////////////////////////////////////////
  // Bit cells; the clock stands still outside frames
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase <= 3'h0;
      bit_idx <= 0;
      word_clock <= 1'b0;
      serial_in <= 1'b0;
      frame_done <= 1'b0;
    end else if (!run) begin
      phase <= 3'h0;
      bit_idx <= 0;
      word_clock <= 1'b0;
      frame_done <= 1'b0;
      // Released line: toggles so no stale level is mistaken for data
      serial_in <= ~serial_in;
    end else if (bit_idx < BITS || phase != 3'h0) begin
      phase <= phase + 3'h1;
      // Data set up in the low half, well before the rising edge
      if (phase == 3'h1) begin
        serial_in <= (bit_idx == BITS - 1) ? parity_bit : 1'b0;
      end
      if (phase == 3'h3) begin
        word_clock <= 1'b1;
        bit_idx <= bit_idx + 1;
      end
      if (phase == 3'h7) begin
        word_clock <= 1'b0;
      end
    end else begin
      frame_done <= 1'b1;
      serial_in <= ~serial_in;
    end
  end
endmodule

// ==== tb/tb_disc_word_buffer.sv ====
// Self-checking bench of the disc word buffer.
`timescale 1ns/100ps
module tb_disc_word_buffer
  import disc_buffer_pkg::*;
;
  ////////////////////////////////////////////////////////////////
  // Stimulus, outputs and bookkeeping
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic sub_go = 1'b0;
  logic wr_gate = 1'b0;
  logic rd_gate = 1'b0;
  logic sect_go = 1'b0;
  logic run = 1'b0;
  logic par = 1'b1;
  logic ce = 1'b1;
  logic wclk_q = 1'b0;
  logic [15:0] rdata;
  logic wclk, sin, sout, done, e_n, full, full_n, drs, s_ld, h_x, b_wr, sr_ld, taken;
  logic rd_err, c_cyc, p_cyc;
  int error_cnt = 0;
  int checks_done = 0;
  int cycles = 0;
  // Pulse counters, cleared between tests on the falling edge
  localparam int UP = 0, DN = 1, DRS = 2, LD = 3, SHL = 4, HX = 5, TK = 6, CC = 7;
  localparam int PC = 8, ONES = 9;
  int cnt [10];
  typedef struct packed {logic [15:0] ctrl; logic [4:0] occ; logic full;} row_t;
  // Init modes: control word, occupancy and full flag expected
  row_t rows [4] = '{'{16'h0006, 5'h1f, 1'b1}, '{16'h0004, 5'h0f, 1'b0},
    '{16'h0007, 5'h1f, 1'b1}, '{16'h0005, 5'h0f, 1'b0}};

  disc_word_buffer dut_u (.clk(clk), .arst_n(arst_n), .ce(ce), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .word_clock(wclk), .subsector_start(sub_go),
    .write_active_flag(wr_gate), .read_gate(rd_gate), .write_sector_go(sect_go),
    .serial_in(sin), .serial_out(sout), .buffer_empty_n(e_n), .buffer_full_flag(full),
    .buffer_full_n(full_n), .data_register_strobe(drs), .buffer_to_serial_load_pulse(s_ld),
    .buffer_to_host_transfer_pulse(h_x), .buffer_write_pulse(b_wr),
    .shift_register_load_pulse(sr_ld), .data_taken_strobe(taken), .read_check_error(rd_err),
    .check_word_cycle_flag(c_cyc), .parity_cycle_flag(p_cyc));
  disc_serial_model disc_u (.clk(clk), .arst_n(arst_n), .run(run), .parity_bit(par),
    .word_clock(wclk), .serial_in(sin), .frame_done(done));

  always #5 clk = ~clk;

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // Monitor: pulse counts, transfer sanity, hang guard
  always @(posedge clk) begin
    cycles++;
    cnt[UP] += int'(s_ld) + int'(b_wr);
    cnt[DN] += int'(sr_ld) + int'(h_x);
    cnt[DRS] += int'(drs);
    cnt[LD] += int'(s_ld);
    cnt[SHL] += int'(sr_ld);
    cnt[HX] += int'(h_x);
    cnt[TK] += int'(taken);
    cnt[CC] += int'(c_cyc);
    cnt[PC] += int'(p_cyc);
    // Written bit is settled by the falling word clock edge
    cnt[ONES] += int'(wclk_q && !wclk && sout);
    wclk_q = wclk;
    if (h_x === 1'b1) chk("strobe_with_xfer", 16'h1, {15'h0, drs});
    if ((c_cyc | p_cyc) === 1'b1) chk("xfer_in_check", 16'h0, {15'h0, h_x | s_ld});
    if (cycles == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////
  // Register bus master; one strobe cycle per access
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask

  task automatic stat(output status_t s);
    logic [15:0] d;
    rd(OFF_STATUS, d);
    s = status_t'(d);
  endtask

  task automatic clr();
    @(negedge clk);
    cnt = '{default: 0};
  endtask

  // Bounded wait on a pulse count
  task automatic wait_for(input int idx, input int n);
    int k;
    k = 0;
    while (cnt[idx] < n && k < 1000) begin
      @(posedge clk);
      k++;
    end
  endtask

  // One subsector through the disc model, then the end hold-off
  task automatic frame(input logic is_rd, input logic p);
    int k;
    k = 0;
    @(posedge clk);
    sub_go <= 1'b1;
    rd_gate <= is_rd;
    wr_gate <= !is_rd;
    sect_go <= !is_rd;
    par <= p;
    @(posedge clk);
    sub_go <= 1'b0;
    run <= 1'b1;
    while (done !== 1'b1 && k < 4000) begin
      @(posedge clk);
      k++;
    end
    run <= 1'b0;
    rd_gate <= 1'b0;
    wr_gate <= 1'b0;
    sect_go <= 1'b0;
    // Hold-off is 200 cycles; margin added
    repeat (220) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    status_t s;
    logic [15:0] d;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    stat(s);
    chk("occupancy", 16'h000f, 16'(s.occupancy));
    chk("empty_n", 16'h0, 16'(e_n));
    chk("full_pair", 16'h1, {14'h0, full, full_n});
    $display("test reset done");
    foreach (rows[i]) begin
      wr(OFF_CTRL, rows[i].ctrl);
      stat(s);
      chk("occupancy", 16'(rows[i].occ), 16'(s.occupancy));
      chk("empty_n", 16'(rows[i].occ[4]), 16'(e_n));
      chk("full_pair", {14'h0, rows[i].full, !rows[i].full}, {14'h0, full, full_n});
    end
    rd(4'h2, d);
    chk("unmapped_read", 16'h0, d);
    wr(4'h6, 16'hffff);
    stat(s);
    chk("occupancy", 16'h000f, 16'(s.occupancy));
    $display("test init modes done");
    // Read with a slow host: second transfer waits for the take
    wr(OFF_CTRL, 16'h0005);
    clr();
    fork
      frame(1'b1, 1'b1);
      begin
        wait_for(HX, 1);
        repeat (100) @(posedge clk);
        chk("held_while_full", 16'h1, 16'(cnt[HX]));
        rd(OFF_DATA, d);
        chk("host_word", 16'h0, d);
        @(posedge clk);
        chk("taken", 16'h1, 16'(cnt[TK]));
        wait_for(HX, 2);
        chk("next_xfer", 16'h2, 16'(cnt[HX]));
      end
    join
    rd(OFF_ERROR, d);
    chk("error_word", 16'h0, d);
    stat(s);
    chk("occupancy", 16'(5'h0f + cnt[UP] - cnt[DN]), 16'(s.occupancy));
    chk("words_in", 16'd16, 16'(cnt[UP]));
    chk("check_cycles", 16'd128, 16'(cnt[CC]));
    chk("parity_cycles", 16'd8, 16'(cnt[PC]));
    $display("test read done");
    // Bad parity bit on an all-zero subsector
    wr(OFF_CTRL, 16'h0005);
    stat(s);
    chk("data_full", 16'h0, 16'(s.data_register_full_flag));
    frame(1'b1, 1'b0);
    rd(OFF_ERROR, d);
    chk("error_word", 16'h8000, d);
    chk("error_pin", 16'h1, 16'(rd_err));
    wr(OFF_CTRL, 16'h0005);
    rd(OFF_ERROR, d);
    chk("error_clear", 16'h0, d);
    $display("test read error done");
    // Write: two host words go through buffer and shifter
    wr(OFF_CTRL, 16'h0004);
    clr();
    fork
      frame(1'b0, 1'b1);
      begin
        wr(OFF_DATA, 16'ha5a5);
        wait_for(LD, 1);
        wr(OFF_DATA, 16'h5a5a);
        wait_for(LD, 2);
      end
    join
    stat(s);
    chk("strobes", 16'h2, 16'(cnt[DRS]));
    chk("loads", 16'h2, 16'(cnt[LD]));
    chk("shift_loads", 16'h2, 16'(cnt[SHL]));
    chk("occupancy", 16'h000f, 16'(s.occupancy));
    chk("odd_ones", 16'h1, 16'(cnt[ONES] % 2));
    $display("test write done");
    // Clock enable low: an init write must leave the occupancy alone
    ce <= 1'b0;
    wr(OFF_CTRL, 16'h0006);
    ce <= 1'b1;
    stat(s);
    chk("frozen_occupancy", 16'h000f, 16'(s.occupancy));
    $display("test clock enable done");
    test_done();
  end
endmodule
